/* File: design/ledspi_pkg.sv */
package ledspi_pkg;

   // Frame layout of a command on the serial input.
   localparam int FB_WRITE = 15;
   localparam int FB_BANK = 14;
   localparam int FB_IDX_HI = 13;
   localparam int FB_IDX_LO = 8;
   localparam int FB_DIAG_REQ = 0;
   localparam int FRAME_W = 16;

   // Field positions inside the standard diagnosis word.
   localparam int DB_GATE = 14;
   localparam int DB_SUPPLY = 13;
   localparam int DB_STATE_HI = 12;
   localparam int DB_STATE_LO = 11;
   localparam int DB_TER = 10;
   localparam int DB_MON = 9;
   localparam int DB_SEQ = 8;
   localparam int DB_CAL = 7;
   localparam int DB_INOV = 6;
   localparam int DB_OUTPUT_OVERVOLTAGE = 5;
   localparam int DB_IVCC = 4;
   localparam int DB_OL = 3;
   localparam int DB_SHRT = 2;
   localparam int DB_TSD = 1;
   localparam int DB_TW = 0;

   // Register indices of bank zero.
   localparam logic [5:0] RI_DIMMING = 6'h00;
   localparam logic [5:0] RI_CALIB = 6'h03;
   localparam logic [5:0] RI_SWITCH = 6'h05;
   localparam logic [5:0] RI_DEVCTL = 6'h06;
   localparam logic [5:0] RI_SEQ1 = 6'h09;
   localparam logic [5:0] RI_SEQ2 = 6'h0a;
   localparam logic [5:0] RI_MONITOR = 6'h0c;
   localparam logic [5:0] RI_REGMON = 6'h0f;

   // Bit positions inside the routine, switching and device control registers.
   localparam int CB_START = 5;
   localparam int CB_DONE = 4;
   localparam int SW_OVLATCH = 4;
   localparam int DC_CALEN = 3;
   localparam int DC_CLEAR = 2;
   localparam int DC_SOFTRST = 1;
   localparam int DC_IDLE = 0;
   localparam logic [7:0] WM_ROUTINE = 8'hcf;
   localparam logic [7:0] WM_DEVCTL = 8'hf9;
   localparam logic [7:0] WM_ALL = 8'hff;

   // Reset values and frame length checks.
   localparam logic [7:0] DIM_RESET = 8'hf0;
   localparam logic [15:0] DIAG_RESET = 16'h2000;
   localparam logic [15:0] DIAG_QUIET = 16'h1000;
   localparam logic [4:0] MIN_BITS = 5'h10;
   localparam logic [2:0] LO3_ONE = 3'h1;
   localparam logic [4:0] N5_ONE = 5'h01;
   localparam logic [1:0] OPST_ACTIVE = 2'h2;

   typedef enum logic [1:0] {RESP_DIAG = 2'b01, RESP_REG = 2'b10} ledspi_resp_t;

   typedef struct packed {
      logic supply_uv;
      logic input_ov;
      logic output_ov;
      logic internal_uv;
      logic open_load;
      logic shorted_led;
      logic thermal_sd;
      logic temp_warning;
      logic gate_uv;
      logic [1:0] op_state;
      logic monitor_ok;
      logic sequence_ok;
      logic calib_ok;
   } ledspi_mon_t;

   typedef struct packed {
      logic supply_uv;
      logic transmission_error;
      logic input_ov;
      logic output_ov;
      logic internal_uv;
      logic open_load;
      logic shorted_led;
      logic thermal_sd;
      logic soft_reset;
   } ledspi_flags_t;

   typedef struct packed {
      logic halt;
      logic calib_start;
      logic monitor_start;
      logic sequence_start;
      logic soft_reset;
      logic idle;
      logic calib_enable;
   } ledspi_ctl_t;

   typedef struct packed {
      logic [2:0] csn_sync;
      ledspi_mon_t mon_s1;
      ledspi_mon_t mon_s2;
      ledspi_flags_t flags;
      logic [63:0][7:0] regs;
      ledspi_resp_t resp;
      logic [15:0] tx;
      ledspi_ctl_t ctl;
   } ledspi_sys_t;

   typedef struct packed {
      logic [15:0] sh;
      logic [4:0] n5;
      logic [2:0] lo3;
   } ledspi_link_t;

endpackage

/* File: design/ledspi_core.sv */
`timescale 1ns/100ps
// Operation
// R1 - Frame: bit15 write, bit14 bank, bits13..8 index, bits7..0 data.
// R2 - Master reads diagnosis with bit0 high, bank-zero register with bits 15,14,0 low.
// R3 - Read answer is shifted out during the frame after the command.
// R4 - Register answers carry MSB high; diagnosis answers carry MSB low.
// R5 - A new command is decoded in the frame that returns the previous answer.
// R6 - Fault and error flags latch and clear after a diagnosis read.
// R7 - Clear-latches command clears latched flags, overvoltage and thermal protections, resumes switching.
// R8 - Output overvoltage stays latched over reads while its latch enable is one.
// R9 - Thermal shutdown always latches; only clear-latches clears it.
// R10 - Live monitors and mirrors are untouched by reads and clear-latches.
// R11 - Operating state and temperature warning are live, never latched.
// R12 - Routine done bits mirror the done bits of their configuration registers.
// R13 - Bit 14 is soft-reset flag ORed with live gate-driver undervoltage.
// R14 - Active, fault-free, no routines run: diagnosis reads 1000 hex.
// R15 - State field 12:11: 00 reserved, 01 limp home, 10 active, 11 idle.
// R16 - Bit 13 shows supply or enable undervoltage since last diagnosis read.
// R17 - Bit 10 shows whether the previous transmission was in error.
// R18 - Bit 9 shows monitor done; writing monitor start clears it.
// R19 - Bit 8 shows sequence done; setting sequence start clears it.
// R20 - Bit 7 shows calibration done; setting calibration start clears it.
// R21 - Bit 6 shows input overvoltage since last diagnosis read.
// R22 - Bit 5 shows output overvoltage since last diagnosis read.
// R23 - Bits 3..0: open load, shorted LED, thermal shutdown, temperature warning.
// R24 - Unimplemented index: writes ignored, reads answer with diagnosis word.
// R25 - Clock count not a multiple of eight or below sixteen is a transmission error.
module ledspi_core
   import ledspi_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csn_b,
   input wire logic si,
   output logic so,
   output logic so_oe_b,
   input ledspi_mon_t mon,
   output ledspi_ctl_t ctl
);

   // Index decoder: only the documented bank-zero registers exist.
   function automatic logic reg_impl(input logic [5:0] idx);
      case (idx)
         RI_DIMMING, RI_CALIB, RI_SWITCH, RI_DEVCTL: reg_impl = 1'b1;
         RI_SEQ1, RI_SEQ2, RI_MONITOR, RI_REGMON: reg_impl = 1'b1;
         default: reg_impl = 1'b0;
      endcase
   endfunction

   // Bits that software may store; start and command bits self-clear, done bits are read only.
   function automatic logic [7:0] wr_mask(input logic [5:0] idx);
      case (idx)
         RI_CALIB, RI_SEQ1, RI_MONITOR: wr_mask = WM_ROUTINE;
         RI_DEVCTL: wr_mask = WM_DEVCTL;
         default: wr_mask = WM_ALL;
      endcase
   endfunction

   // Assembles the standard diagnosis word; bit 15 stays low.
   function automatic logic [15:0] diag_word(input ledspi_flags_t f, input ledspi_mon_t m,
                                              input logic [63:0][7:0] r);
      logic [15:0] w;
      w = '0;
      w[DB_GATE] = f.soft_reset | m.gate_uv; // see R13
      w[DB_SUPPLY] = f.supply_uv; // see R16
      w[DB_STATE_HI:DB_STATE_LO] = m.op_state; // see R11, see R15
      w[DB_TER] = f.transmission_error; // see R17
      w[DB_MON] = r[RI_MONITOR][CB_DONE]; // see R12, see R18
      w[DB_SEQ] = r[RI_SEQ1][CB_DONE]; // see R19
      w[DB_CAL] = r[RI_CALIB][CB_DONE]; // see R20
      w[DB_INOV] = f.input_ov; // see R21
      w[DB_OUTPUT_OVERVOLTAGE] = f.output_ov; // see R22
      w[DB_IVCC] = f.internal_uv;
      w[DB_OL] = f.open_load; // see R23
      w[DB_SHRT] = f.shorted_led;
      w[DB_TSD] = f.thermal_sd;
      w[DB_TW] = m.temp_warning;
      return w;
   endfunction

   // Reset release: asserted at once, released after two clean edges.
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Link side. Bits are taken on the falling serial clock. The fresh flag is set
   // while the select is idle, so the first falling edge of a frame restarts counting.
   ledspi_link_t lk_q;
   ledspi_link_t lk_d;
   ledspi_sys_t st_q;
   ledspi_sys_t st_d;
   logic fresh_q;
   logic [4:0] out_idx;
   logic [15:0] tx_flip;

   always_comb begin
      lk_d = lk_q;
      lk_d.sh = {lk_q.sh[14:0], si}; // see R1
      if (fresh_q) begin
         lk_d.n5 = N5_ONE;
         lk_d.lo3 = LO3_ONE;
      end else begin
         lk_d.n5 = (lk_q.n5 == MIN_BITS) ? lk_q.n5 : lk_q.n5 + N5_ONE;
         lk_d.lo3 = lk_q.lo3 + LO3_ONE;
      end
   end

   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   always_ff @(negedge sclk or posedge csn_b) begin
      if (csn_b) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   // The answer word is loaded by the system side only between frames, so it is
   // stable while the link shifts it; bits beyond the sixteenth read as zero.
   assign out_idx = fresh_q ? 5'h00 : lk_q.n5;
   assign tx_flip = {<<{st_q.tx}};

   always_ff @(posedge sclk or posedge csn_b) begin
      if (csn_b) begin
         so <= 1'b0;
         so_oe_b <= 1'b1;
      end else begin
         so <= (out_idx < MIN_BITS) ? tx_flip[out_idx[3:0]] : 1'b0; // see R3
         so_oe_b <= 1'b0;
      end
   end

   // System side state and frame decode.
   logic frame_end;
   logic bad;
   logic [15:0] word;
   logic [5:0] idx;
   logic [7:0] dat;
   logic impl;
   logic do_wr;
   logic clr_cmd;
   logic rd_clr;
   logic ovlatch;

   // The select rising edge is seen after synchronising; the serial clock is idle by
   // then, so the link counters and shift register are stable when sampled here.
   assign frame_end = st_q.csn_sync[1] & ~st_q.csn_sync[2];
   assign bad = (lk_q.lo3 != 3'h0) | (lk_q.n5 < MIN_BITS); // see R25
   assign word = lk_q.sh;
   assign idx = word[FB_IDX_HI:FB_IDX_LO];
   assign dat = word[7:0];
   assign impl = reg_impl(idx) & ~word[FB_BANK];
   assign do_wr = frame_end & ~bad & word[FB_WRITE] & impl; // see R24
   assign clr_cmd = do_wr & (idx == RI_DEVCTL) & dat[DC_CLEAR];
   assign rd_clr = frame_end & ~bad & (st_q.resp == RESP_DIAG);
   assign ovlatch = st_q.regs[RI_SWITCH][SW_OVLATCH];

   always_comb begin
      logic [15:0] rc;
      logic rd_reg;
      st_d = st_q;
      rc = rd_clr ? st_q.tx : 16'h0000;
      rd_reg = ~bad & ~word[FB_WRITE] & ~word[FB_DIAG_REQ] & impl;
      st_d.csn_sync = {st_q.csn_sync[1:0], csn_b};
      st_d.mon_s1 = mon;
      st_d.mon_s2 = st_q.mon_s1;
      st_d.ctl.calib_start = 1'b0;
      st_d.ctl.monitor_start = 1'b0;
      st_d.ctl.sequence_start = 1'b0;
      st_d.ctl.soft_reset = 1'b0;
      // Read clears act only on bits that were shifted out, so a fault seen after the
      // word was loaded survives the read; a set in the same cycle always wins.
      st_d.flags.supply_uv = (st_q.flags.supply_uv & ~rc[DB_SUPPLY] & ~clr_cmd)
                             | st_q.mon_s2.supply_uv; // see R6, see R16
      st_d.flags.transmission_error = (st_q.flags.transmission_error & ~rc[DB_TER] & ~clr_cmd)
                       | (frame_end & bad); // see R17, see R25
      st_d.flags.input_ov = (st_q.flags.input_ov & ~rc[DB_INOV] & ~clr_cmd)
                            | st_q.mon_s2.input_ov; // see R21
      st_d.flags.output_ov = (st_q.flags.output_ov & ~(rc[DB_OUTPUT_OVERVOLTAGE] & ~ovlatch) & ~clr_cmd)
                             | st_q.mon_s2.output_ov; // see R8, see R22
      st_d.flags.internal_uv = (st_q.flags.internal_uv & ~rc[DB_IVCC] & ~clr_cmd)
                               | st_q.mon_s2.internal_uv;
      st_d.flags.open_load = (st_q.flags.open_load & ~rc[DB_OL] & ~clr_cmd)
                             | st_q.mon_s2.open_load;
      st_d.flags.shorted_led = (st_q.flags.shorted_led & ~rc[DB_SHRT] & ~clr_cmd)
                               | st_q.mon_s2.shorted_led;
      st_d.flags.thermal_sd = (st_q.flags.thermal_sd & ~clr_cmd)
                              | st_q.mon_s2.thermal_sd; // see R7, see R9
      st_d.flags.soft_reset = (st_q.flags.soft_reset & ~(rc[DB_GATE] & rd_clr))
                              | (do_wr & (idx == RI_DEVCTL) & dat[DC_SOFTRST]); // see R13
      // Register writes keep read-only bits and turn start bits into strobes.
      if (do_wr) begin
         st_d.regs[idx] = (dat & wr_mask(idx)) | (st_q.regs[idx] & ~wr_mask(idx));
         if (dat[CB_START]) begin
            case (idx)
               RI_CALIB: begin
                  st_d.regs[RI_CALIB][CB_DONE] = 1'b0; // see R20
                  st_d.ctl.calib_start = 1'b1;
               end
               RI_SEQ1: begin
                  st_d.regs[RI_SEQ1][CB_DONE] = 1'b0; // see R19
                  st_d.ctl.sequence_start = 1'b1;
               end
               RI_MONITOR: begin
                  st_d.regs[RI_MONITOR][CB_DONE] = 1'b0; // see R18
                  st_d.ctl.monitor_start = 1'b1;
               end
               default: begin
               end
            endcase
         end
         st_d.ctl.soft_reset = (idx == RI_DEVCTL) & dat[DC_SOFTRST];
      end
      // Routine completions set their done bits and win over a start clear.
      if (st_q.mon_s2.calib_ok) begin
         st_d.regs[RI_CALIB][CB_DONE] = 1'b1;
      end
      if (st_q.mon_s2.sequence_ok) begin
         st_d.regs[RI_SEQ1][CB_DONE] = 1'b1;
      end
      if (st_q.mon_s2.monitor_ok) begin
         st_d.regs[RI_MONITOR][CB_DONE] = 1'b1;
      end
      st_d.ctl.idle = st_d.regs[RI_DEVCTL][DC_IDLE];
      st_d.ctl.calib_enable = st_d.regs[RI_DEVCTL][DC_CALEN];
      // Switching halts on latched thermal or latched output overvoltage faults.
      st_d.ctl.halt = st_d.flags.thermal_sd
                      | (st_d.regs[RI_SWITCH][SW_OVLATCH] & st_d.flags.output_ov); // see R7
      // The answer for the next frame is chosen as this frame closes.
      if (frame_end) begin
         st_d.resp = rd_reg ? RESP_REG : RESP_DIAG; // see R5, see R24
         case (st_d.resp)
            RESP_REG: st_d.tx = {1'b1, 1'b0, idx, st_q.regs[idx]}; // see R3, see R4
            RESP_DIAG: st_d.tx = diag_word(st_d.flags, st_q.mon_s2, st_d.regs); // see R4, see R10
            default: st_d.tx = DIAG_RESET;
         endcase
      end
   end

   // Supply undervoltage counts as seen at power-up, so the first answer flags it.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.csn_sync <= 3'h7;
         st_q.regs[RI_DIMMING] <= DIM_RESET;
         st_q.flags.supply_uv <= 1'b1;
         st_q.resp <= RESP_DIAG;
         st_q.tx <= DIAG_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign ctl = st_q.ctl;

   // Checks on the system side.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_answer_msb_kind: assert property (frame_end |=> st_q.tx[FB_WRITE] == (st_q.resp == RESP_REG)) // see R4
      else $error("answer MSB does not match answer kind");
   a_read_reg_answer: assert property (frame_end && !bad && !word[FB_WRITE] && !word[FB_DIAG_REQ]
      && impl |=> st_q.resp == RESP_REG && st_q.tx[7:0] == $past(st_q.regs[idx])) // see R3
      else $error("register read answer wrong");
   a_bad_frame_ter: assert property (frame_end && bad |=> st_q.resp == RESP_DIAG
      && st_q.tx[DB_TER] && st_q.flags.transmission_error) // see R25
      else $error("bad frame not flagged");
   a_tsd_keeps_read: assert property (rd_clr && !clr_cmd && st_q.flags.thermal_sd
      |=> st_q.flags.thermal_sd) // see R9
      else $error("thermal flag cleared by read");
   a_clear_latches: assert property (clr_cmd && !st_q.mon_s2.thermal_sd
      && !st_q.mon_s2.output_ov |=> !st_q.flags.thermal_sd && !st_q.flags.output_ov
      && !st_q.ctl.halt ##1 !st_q.ctl.halt || st_q.flags.thermal_sd) // see R7
      else $error("clear latches did not release protections");
   a_ov_latched_read: assert property (rd_clr && !clr_cmd && ovlatch && st_q.flags.output_ov
      |=> st_q.flags.output_ov) // see R8
      else $error("latched output overvoltage cleared by read");
   a_ov_read_clears: assert property (rd_clr && !clr_cmd && !ovlatch && st_q.tx[DB_OUTPUT_OVERVOLTAGE]
      && !st_q.mon_s2.output_ov |=> !st_q.flags.output_ov) // see R6
      else $error("output overvoltage not cleared by read");
   a_state_live: assert property (frame_end && !bad && !word[FB_WRITE] && word[FB_DIAG_REQ]
      |=> st_q.tx[DB_STATE_HI:DB_STATE_LO] == $past(st_q.mon_s2.op_state)
      && st_q.tx[DB_TW] == $past(st_q.mon_s2.temp_warning)) // see R11
      else $error("live state field stale");
   a_quiet_word: assert property (frame_end && !bad && word[FB_DIAG_REQ] && !word[FB_WRITE]
      && st_q.flags == '0 && st_q.mon_s2 == ledspi_mon_t'({OPST_ACTIVE, 3'h0})
      && !st_q.regs[RI_CALIB][CB_DONE] && !st_q.regs[RI_SEQ1][CB_DONE]
      && !st_q.regs[RI_MONITOR][CB_DONE] |=> st_q.tx == DIAG_QUIET) // see R14
      else $error("quiet diagnosis word wrong");
   a_monitor_start: assert property (do_wr && idx == RI_MONITOR && dat[CB_START]
      && !st_q.mon_s2.monitor_ok |=> !st_q.regs[RI_MONITOR][CB_DONE] && st_q.ctl.monitor_start
      ##1 !st_q.ctl.monitor_start) // see R18
      else $error("monitor start did not clear done");
   a_unimpl_write: assert property (frame_end && !bad && word[FB_WRITE] && !impl
      |=> st_q.regs == $past(st_q.regs) && st_q.resp == RESP_DIAG) // see R24
      else $error("unimplemented write changed state");
   a_soft_reset_bit: assert property (do_wr && idx == RI_DEVCTL && dat[DC_SOFTRST]
      |=> st_q.flags.soft_reset && st_q.tx[DB_GATE]) // see R13
      else $error("soft reset not reported");

   c_read_then_read: cover property (frame_end && st_q.resp == RESP_REG && !bad);
   c_bad_frame: cover property (frame_end && bad);
   c_clear_cmd: cover property (clr_cmd && st_q.flags.thermal_sd);
   c_quiet_word: cover property (frame_end && st_q.tx == DIAG_QUIET);

endmodule

/* File: sim/ledspi_master_model.sv */
`timescale 1ns/100ps
module ledspi_master_model (
   output logic sclk,
   output logic csn_b,
   output logic si,
   input wire logic so,
   input wire logic so_oe_b
);
   // Idle levels: select has a pull-up, clock and data have pull-downs, clock stands still.
   initial begin
      sclk = 1'h0;
      csn_b = 1'h1;
      si = 1'h0;
   end

   // One frame of nbits clocks at 125 ns; the last 16 bits carry the command, MSB first.
   // Data changes on the rising clock so the device samples a settled level on the falling one.
   task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rx);
      int k;
      rx = 16'h0000;
      #37.3 csn_b = 1'h0;
      #200;
      for (int i = 0; i < nbits; i++) begin
         k = nbits - 1 - i;
         sclk = 1'h1;
         si = (k < 16) ? cmd[k] : ~si;
         #62.5 sclk = 1'h0;
         // A released output reads as unknown so it can never pass for an answer.
         if (i < 16) rx[15 - i] = (so_oe_b === 1'h0) ? so : 1'hx;
         #62.5;
      end
      #137.5 csn_b = 1'h1;
      si = 1'h0;
      // The gap covers the device's frame processing before the next word may start.
      #400;
   endtask
endmodule

/* File: sim/spi_command_and_diag_status_tb_top.sv */
`timescale 1ns/100ps
module spi_command_and_diag_status_tb_top
   import ledspi_pkg::*;
();
   logic mclk;
   logic rst_b;
   logic sclk;
   logic csn_b;
   logic si;
   logic so;
   logic so_oe_b;
   ledspi_mon_t mon;
   ledspi_ctl_t ctl;
   logic [15:0] rx;
   logic [31:0] seed;
   logic [5:0] idx;
   int n_fail;
   int num_checks;
   int n_start[3];
   int n_soft;
   int mb[7] = '{13, 12, 11, 10, 9, 8, 7};
   logic [15:0] db[7] = '{16'h2000, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002};
   logic [5:0] ri[3] = '{RI_CALIB, RI_SEQ1, RI_MONITOR};
   int bl[3] = '{8, 12, 17};

   ledspi_core u_dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .csn_b(csn_b), .si(si),
      .so(so), .so_oe_b(so_oe_b), .mon(mon), .ctl(ctl));
   ledspi_master_model u_master (.sclk(sclk), .csn_b(csn_b), .si(si), .so(so),
      .so_oe_b(so_oe_b));

   // System clock at 20 MHz.
   initial mclk = 1'h0;
   always #25 mclk = ~mclk;

   // Count strobes so every start command can be shown to give exactly one pulse.
   always @(posedge mclk) begin
      if (ctl.calib_start === 1'h1) n_start[0]++;
      if (ctl.sequence_start === 1'h1) n_start[1]++;
      if (ctl.monitor_start === 1'h1) n_start[2]++;
      if (ctl.soft_reset === 1'h1) n_soft++;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   function automatic logic [15:0] rexp(input logic [5:0] i, input logic [7:0] d);
      return {1'h1, 1'h0, i, d};
   endfunction

   function automatic logic [15:0] dexp(input logic [1:0] s, input logic [15:0] b);
      return {3'h0, s, 11'h000} | b;
   endfunction

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One frame; the answer seen belongs to the frame before.
   task automatic fr(input logic [15:0] cmd, input logic [15:0] exp, input bit chk,
         input int nb = 16);
      u_master.xfer(cmd, nb, rx);
      if (chk) check("answer", rx, exp);
   endtask

   // Monitor levels change on the falling edge and are held long enough to be synchronised.
   task automatic pulse(input int b);
      @(negedge mclk);
      mon = mon | (14'h0001 << b);
      repeat (4) @(negedge mclk);
      mon = mon & ~(14'h0001 << b);
   endtask

   // A change shows in the second frame, since the answer is snapshotted a frame late.
   task automatic latch_seq(input int b, input logic [15:0] e1, input logic [15:0] e2);
      pulse(b);
      fr(16'h0001, 16'h0000, 0);
      fr(16'h0001, e1, 1);
      fr(16'h0001, 16'h0000, 0);
      fr(16'h0001, e2, 1);
   endtask

   task automatic clear_latches();
      fr(16'h8604, 16'h0000, 0);
      fr(16'h0001, 16'h0000, 0);
      fr(16'h0001, DIAG_QUIET, 1);
   endtask

   // The watchdog span is several times the expected length of the whole sequence.
   initial begin
      #2_000_000;
      n_fail++;
      close_out();
   end

   initial begin
      seed = 32'h0000_1163;
      n_fail = 0;
      num_checks = 0;
      n_soft = 0;
      rst_b = 1'h0;
      mon = '0;
      mon.op_state = OPST_ACTIVE;
      repeat (3) @(negedge mclk);
      rst_b = 1'h1;
      repeat (4) @(negedge mclk);
      fr(16'h0001, DIAG_RESET, 1);
      fr(16'h0000, 16'h0000, 0);
      fr(16'h0001, rexp(RI_DIMMING, DIM_RESET), 1);
      fr(16'h0001, DIAG_QUIET, 1);
      // Pipelined write and two back-to-back reads with random data.
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         idx = seed[8] ? RI_SEQ2 : RI_DIMMING;
         fr({1'h1, 1'h0, idx, seed[7:0]}, 16'h0000, 0);
         fr({1'h0, 1'h0, idx, 8'h00}, DIAG_QUIET, 1);
         fr({1'h0, 1'h0, idx, 8'h00}, rexp(idx, seed[7:0]), 1);
      end
      // Unused index and bank one are answered with the diagnosis word.
      fr(16'h81a5, 16'h0000, 0);
      fr(16'h0100, DIAG_QUIET, 1);
      fr(16'h4000, DIAG_QUIET, 1);
      fr(16'h0001, DIAG_QUIET, 1);
      // Bad clock counts, each flagged and cleared by the next 16-clock diagnosis read, then a good 24-clock frame raises no error.
      for (int i = 0; i < 3; i++) begin
         fr(16'h0001, 16'h0000, 0, bl[i]);
         fr(16'h0001, DIAG_QUIET | 16'h0400, 1);
         fr(16'h0001, 16'h0000, 0, 24);
         fr(16'h0001, DIAG_QUIET, 1);
      end
      for (int k = 0; k < 6; k++) latch_seq(mb[k], DIAG_QUIET | db[k], DIAG_QUIET);
      latch_seq(mb[6], DIAG_QUIET | db[6], DIAG_QUIET | db[6]);
      check("halt", {15'h0000, ctl.halt}, 16'h0001);
      clear_latches();
      check("halt", {15'h0000, ctl.halt}, 16'h0000);
      fr(16'h8510, 16'h0000, 0);
      latch_seq(mb[2], DIAG_QUIET | db[2], DIAG_QUIET | db[2]);
      clear_latches();
      fr(16'h8500, 16'h0000, 0);
      // Live fields follow the monitors with no latching.
      for (int s = 0; s < 4; s++) begin
         @(negedge mclk);
         mon.op_state = 2'(s);
         mon.temp_warning = s[0];
         fr(16'h0001, 16'h0000, 0);
         fr(16'h0001, dexp(2'(s), {15'h0000, s[0]}), 1);
      end
      @(negedge mclk);
      mon.op_state = OPST_ACTIVE;
      mon.temp_warning = 1'h0;
      mon.gate_uv = 1'h1;
      fr(16'h0001, 16'h0000, 0);
      fr(16'h0001, 16'h5000, 1);
      @(negedge mclk);
      mon.gate_uv = 1'h0;
      fr(16'h0001, 16'h0000, 0);
      fr(16'h0001, DIAG_QUIET, 1);
      fr(16'h8602, 16'h0000, 0);
      fr(16'h0001, 16'h5000, 1);
      fr(16'h0001, DIAG_QUIET, 1);
      check("soft", 16'(n_soft), 16'h0001);
      // Routine done bits mirror the register and fall when the start bit is written.
      for (int k = 0; k < 3; k++) begin
         pulse(k);
         fr({1'h0, 1'h0, ri[k], 8'h00}, 16'h0000, 0);
         fr(16'h0001, rexp(ri[k], 8'h10), 1);
         fr(16'h0001, DIAG_QUIET | (16'h0080 << k), 1);
         fr({1'h1, 1'h0, ri[k], 8'h20}, 16'h0000, 0);
         fr(16'h0001, 16'h0000, 0);
         fr(16'h0001, DIAG_QUIET, 1);
         check("start", 16'(n_start[k]), 16'h0001);
      end
      fr(16'h8609, 16'h0000, 0);
      check("devctl", {14'h0000, ctl.idle, ctl.calib_enable}, 16'h0003);
      fr(16'h8600, 16'h0000, 0);
      check("devctl", {14'h0000, ctl.idle, ctl.calib_enable}, 16'h0000);
      close_out();
   end
endmodule
